// >>> microprogram_sequencer.sv
// What this block does
// RL1 - Branch mux yields six-bit alteration value.
// RL2 - Low bits select from more sources.
// RL3 - Dispatch encoders give up to five-bit codes.
// RL4 - One instruction bit picks between two addresses.
// RL5 - Flags alter only the lowest address bit.
// RL6 - Branch select field picks alteration sources.
// RL7 - Store holds 256 words, one per state.
// RL8 - Option stores OR onto both store buses.
// RL9 - Buffered word runs while store fetches next.
// RL10 - Microword loads at each state start.
// RL11 - Load edge follows previous cycle length.
// RL12 - Address field passes inverting OR gate.
// RL13 - Pointer loads as old value addresses store.
// RL14 - Past address register holds executing address.
// RL15 - Stored address is complemented, gate re-inverts.
// RL16 - Mux outputs ORed into zero base bits.
// RL17 - Branch in A changes C, not B.
// RL18 - Branch selected one word ahead.
// RL19 - Forced address overrides next address field.
// RL20 - Forcing acts directly, on the next clock edge in any state.
// RL21 - Three cycle types: one, one, two pulses.
// RL22 - Past register clocks with the microword.
// RL23 - Pointer and past register nine bits.
// RL24 - Without branch, advance to stored address.
module microprogram_sequencer #(
  parameter int DEPTH = useq_pkg::STORE_DEPTH
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_in,
  input  wire useq_pkg::branch_src_t         branch_src_in,
  input  wire logic                          force_in,
  input  wire logic [useq_pkg::ADDR_W-1:0]   force_addr_in,
  input  wire logic [useq_pkg::WORD_W-1:0]   option_word_in,
  input  wire logic                          load_in,
  input  wire logic [useq_pkg::STORE_AW-1:0] load_addr_in,
  input  wire logic [useq_pkg::WORD_W-1:0]   load_data_in,
  output logic [useq_pkg::CTRL_W-1:0]        control_out,
  output logic [useq_pkg::ADDR_W-1:0]        next_address_out,
  output logic [useq_pkg::ADDR_W-1:0]        past_address_out,
  output logic                               state_end_out
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // The field map and the eight-bit store address assume exactly 256 words.
  if (DEPTH != useq_pkg::STORE_DEPTH)
  begin : g_bad_depth
    $error("Control store depth must be 256.");
  end

  // ****************************************************************
  // Control store
  // ****************************************************************
  logic [useq_pkg::WORD_W-1:0] store_mem [DEPTH];                      // RL7

  always_ff @(posedge core_clk_in)
  begin
    if (load_in)
      store_mem[load_addr_in] <= load_data_in;
  end

  logic [useq_pkg::ADDR_W-1:0]  pointer_q;
  logic [useq_pkg::ADDR_W-1:0]  past_q;
  logic [useq_pkg::CTRL_W-1:0]  ctrl_q;
  logic [1:0]                   pulse_q;
  logic                         end_q;

  wire [useq_pkg::STORE_AW-1:0] store_addr = pointer_q[useq_pkg::STORE_AW-1:0];
  wire useq_pkg::microword_t    bus_word = store_mem[store_addr] | option_word_in;  // RL8

  // ****************************************************************
  // Branch test multiplexer
  // ****************************************************************
  wire [3:0] bsf = ctrl_q[useq_pkg::BSF_LSB +: useq_pkg::BSF_W];       // RL6
  wire [2:0] flag_sel = ctrl_q[useq_pkg::FLAG_SEL_LSB +: useq_pkg::FLAG_SEL_W];
  wire [3:0] ir_sel = ctrl_q[useq_pkg::IR_SEL_LSB +: useq_pkg::IR_SEL_W];

  wire [4:0] code_sel =                                                 // RL3
    (bsf == useq_pkg::BR_DISP1) ? branch_src_in.disp1 :
    (bsf == useq_pkg::BR_DISP2) ? branch_src_in.disp2 :
    (bsf == useq_pkg::BR_DISP3) ? branch_src_in.disp3 : 5'h00;
  wire ir_bit = branch_src_in.ir[ir_sel];                               // RL4
  wire flag_bit = branch_src_in.flags[flag_sel];                        // RL5
  wire wide_any = (bsf == useq_pkg::BR_DISP1) || (bsf == useq_pkg::BR_DISP2) ||
                  (bsf == useq_pkg::BR_DISP3);

  // Bit 0 has the widest choice; bits 2 and up only follow wide branches.
  wire alt0 = wide_any ? code_sel[0] :                                  // RL2
              (bsf == useq_pkg::BR_NARROW) ? branch_src_in.ir[0] :
              (bsf == useq_pkg::BR_IR_BIT) ? ir_bit :
              (bsf == useq_pkg::BR_FLAG) ? flag_bit :
              (bsf == useq_pkg::BR_WIDE6) ? branch_src_in.ir[0] : 1'b0;
  wire alt1 = wide_any ? code_sel[1] :
              (bsf == useq_pkg::BR_NARROW) ? branch_src_in.ir[1] :
              (bsf == useq_pkg::BR_WIDE6) ? branch_src_in.ir[1] : 1'b0;
  wire [1:0] alt23 = wide_any ? code_sel[3:2] :
                     (bsf == useq_pkg::BR_WIDE6) ? branch_src_in.ir[3:2] : 2'h0;
  wire alt4 = wide_any ? code_sel[4] :                                  // RL1
              (bsf == useq_pkg::BR_WIDE6) ? branch_src_in.ir[4] : 1'b0;
  wire alt5 = (bsf == useq_pkg::BR_WIDE6) ? branch_src_in.ir[5] : 1'b0;
  wire [useq_pkg::ALT_W-1:0] alteration = {alt5, alt4, alt23, alt1, alt0};

  // ****************************************************************
  // Inverting OR gate
  // ****************************************************************
  // The store emits the field complemented; re-inverting and ORing the
  // alteration into zero base bits yields the branch target.
  wire [useq_pkg::ADDR_W-1:0] altered_addr =                            // RL15
    ~bus_word.next_n | {3'h0, alteration};                              // RL16

  // ****************************************************************
  // Machine state length
  // ****************************************************************
  wire [1:0] cyc = ctrl_q[useq_pkg::CYC_LSB +: useq_pkg::CYC_W];        // RL21
  wire [1:0] pulses_needed = (cyc == useq_pkg::CYC_DOUBLE) ?
                             useq_pkg::PULSES_DOUBLE : useq_pkg::PULSES_SINGLE;
  wire state_end = (pulse_q + 2'h1 >= pulses_needed);                   // RL11

  // ****************************************************************
  // Next values of pointer, microword, past address and pulse count
  // ****************************************************************
  // A forced address beats the gate on the same edge and in any state, so an
  // exceptional condition never waits for a double pulse state to finish.
  wire                        take_force = force_in;                          // RL19
  wire                        take_gate  = state_end && !force_in;            // RL13
  wire [useq_pkg::ADDR_W-1:0] pointer_d  = take_force ? force_addr_in :       // RL20
                                           take_gate ? altered_addr : pointer_q;
  wire [useq_pkg::CTRL_W-1:0] ctrl_d     = state_end ? bus_word.ctrl : ctrl_q;
  wire [useq_pkg::ADDR_W-1:0] past_d     = state_end ? pointer_q : past_q;
  wire [1:0]                  pulse_d    = state_end ? 2'h0 : pulse_q + 2'h1;

  // ****************************************************************
  // Next address pointer
  // ****************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      pointer_q <= useq_pkg::NEXT_RESET;
    else
      pointer_q <= pointer_d;                                           // RL13 RL17 RL18 RL24
  end

  // ****************************************************************
  // Microword register
  // ****************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      ctrl_q <= '0;
    else
      ctrl_q <= ctrl_d;                                                 // RL9 RL10 RL12
  end

  // ****************************************************************
  // Past address register
  // ****************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      past_q <= useq_pkg::NEXT_RESET;
    else
      past_q <= past_d;                                                 // RL14 RL22 RL23
  end

  // ****************************************************************
  // Pulse counter
  // ****************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      pulse_q <= 2'h0;
    else
      pulse_q <= pulse_d;                                               // RL21
  end

  // ****************************************************************
  // End of state flag
  // ****************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      end_q <= 1'b0;
    else
      end_q <= state_end;                                               // RL11
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign control_out      = ctrl_q;
  assign next_address_out = pointer_q;
  assign past_address_out = past_q;
  assign state_end_out    = end_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_past_follows_ptr: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL14
    state_end |=> past_q == $past(pointer_q))
    else $error("Past address did not take the pointer.");

  a_force_loads: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL19
    force_in |=> pointer_q == $past(force_addr_in))
    else $error("Forced address not loaded.");

  a_plain_advance: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL24
    (state_end && !force_in && bsf == useq_pkg::BR_NONE) |=> pointer_q == ~$past(bus_word.next_n))
    else $error("Pointer did not take stored address.");

  a_double_len: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL21
    (state_end ##1 cyc == useq_pkg::CYC_DOUBLE) |-> !state_end ##1 state_end)
    else $error("Double pulse cycle length wrong.");

  a_single_len: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL11
    (state_end ##1 cyc != useq_pkg::CYC_DOUBLE) |-> state_end)
    else $error("Single pulse cycle length wrong.");

  a_hold_between: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL10
    (!state_end) |=> $stable(ctrl_q) && $stable(past_q))
    else $error("Microword changed mid state.");

  a_flag_one_bit: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL5
    bsf == useq_pkg::BR_FLAG |-> alteration[5:1] == 5'h00)
    else $error("Flag branch altered upper bits.");

  a_branch_or: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL16
    (state_end && !force_in) |=> (pointer_q[5:0] & $past(alteration)) == $past(alteration))
    else $error("Alteration not ORed into pointer.");

  // ****************************************************************
  // Branch test multiplexer checks
  // ****************************************************************
  // Each select code must reach only the bit positions that its sources own,
  // so a base address with zeros elsewhere is never disturbed.
  a_none_zero: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL24
    bsf == useq_pkg::BR_NONE |-> alteration == 6'h00)
    else $error("Alteration without branch select.");

  a_disp1_code: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL3
    bsf == useq_pkg::BR_DISP1 |-> alteration == {1'b0, branch_src_in.disp1})
    else $error("First dispatch code not passed.");

  a_disp2_code: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL3
    bsf == useq_pkg::BR_DISP2 |-> alteration == {1'b0, branch_src_in.disp2})
    else $error("Second dispatch code not passed.");

  a_disp3_code: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL3
    bsf == useq_pkg::BR_DISP3 |-> alteration == {1'b0, branch_src_in.disp3})
    else $error("Third dispatch code not passed.");

  a_narrow_bits: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL6
    bsf == useq_pkg::BR_NARROW |-> alteration == {4'h0, branch_src_in.ir[1:0]})
    else $error("Narrow branch value wrong.");

  a_ir_bit_value: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL4
    bsf == useq_pkg::BR_IR_BIT |-> alteration == {5'h00, branch_src_in.ir[ir_sel]})
    else $error("Instruction bit branch value wrong.");

  a_flag_value: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL5
    bsf == useq_pkg::BR_FLAG |-> alteration[0] == branch_src_in.flags[flag_sel])
    else $error("Flag branch value wrong.");

  a_wide_six: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL1
    bsf == useq_pkg::BR_WIDE6 |-> alteration == branch_src_in.ir[5:0])
    else $error("Six bit branch value wrong.");

  a_unused_select: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL6
    bsf > useq_pkg::BR_WIDE6 |-> alteration == 6'h00)
    else $error("Unused select code altered the address.");

  a_bit5_sources: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL2
    bsf != useq_pkg::BR_WIDE6 |-> !alteration[5])
    else $error("Bit 5 altered by a narrow source.");

  a_bit4_sources: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL2
    (!wide_any && bsf != useq_pkg::BR_WIDE6) |-> !alteration[4])
    else $error("Bit 4 altered by a narrow source.");

  a_bit23_sources: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL2
    (!wide_any && bsf != useq_pkg::BR_WIDE6) |-> alteration[3:2] == 2'h0)
    else $error("Bits 3 and 2 altered by a narrow source.");

  a_bit1_sources: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL2
    (!wide_any && bsf != useq_pkg::BR_NARROW && bsf != useq_pkg::BR_WIDE6) |-> !alteration[1])
    else $error("Bit 1 altered by a one bit source.");

  // ****************************************************************
  // Address loop checks
  // ****************************************************************
  // The top three pointer bits never take an alteration, so after a gate load they show
  // the re-inverted store field.
  a_upper_fixed: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL15
    take_gate |=> pointer_q[8:6] == ~$past(bus_word.next_n[8:6]))
    else $error("Upper pointer bits not the stored address.");

  a_disp_next: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL18
    (take_gate && bsf == useq_pkg::BR_DISP1) |=>
      pointer_q[4:0] == (~$past(bus_word.next_n[4:0]) | $past(branch_src_in.disp1)))
    else $error("Dispatch branch did not alter the following address.");

  a_pointer_hold: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL13
    (!state_end && !force_in) |=> $stable(pointer_q))
    else $error("Pointer moved inside a state.");

  a_ctrl_from_store: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL9
    state_end |=> ctrl_q == $past(bus_word.ctrl))
    else $error("Microword not taken from the store.");

  a_option_ctrl: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL8
    state_end |=> (ctrl_q & $past(option_word_in[useq_pkg::WORD_W-1:useq_pkg::ADDR_W])) ==
      $past(option_word_in[useq_pkg::WORD_W-1:useq_pkg::ADDR_W]))
    else $error("Option store bits lost.");

  a_past_hold_force: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL22
    (force_in && !state_end) |=> $stable(past_q))
    else $error("Past address moved without a microword load.");

  a_force_ctrl_stable: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL19
    (force_in && !state_end) |=> $stable(ctrl_q))
    else $error("Forcing changed the microword.");

  a_force_at_end: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL20
    (force_in && state_end) |=> pointer_q == $past(force_addr_in))
    else $error("Gate beat the forced address.");

  // ****************************************************************
  // State length checks
  // ****************************************************************
  a_pulse_step: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL21
    !state_end |=> pulse_q == $past(pulse_q) + 2'h1)
    else $error("Pulse count did not advance.");

  a_pulse_clear: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL21
    state_end |=> pulse_q == 2'h0)
    else $error("Pulse count not cleared at state end.");

  a_pulse_bound: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL21
    pulse_q < useq_pkg::PULSES_DOUBLE)
    else $error("Pulse count out of range.");

  a_double_waits: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL21
    (cyc == useq_pkg::CYC_DOUBLE && pulse_q == 2'h0) |-> !state_end)
    else $error("Double pulse state ended after one pulse.");

  a_single_ends: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL21
    cyc != useq_pkg::CYC_DOUBLE |-> state_end)
    else $error("Single pulse state did not end.");

  a_end_copy: assert property (@(posedge core_clk_in) disable iff (reset_in) // RL11
    1'b1 |=> end_q == $past(state_end))
    else $error("State end output wrong.");

  a_reset_clear: assert property (@(posedge core_clk_in) // RL10
    reset_in |=> (pointer_q == useq_pkg::NEXT_RESET && past_q == useq_pkg::NEXT_RESET &&
      ctrl_q == '0 && pulse_q == 2'h0 && !end_q))
    else $error("Registers not cleared by reset.");

endmodule // microprogram_sequencer

// >>> useq_pkg.sv
package useq_pkg;

  // ****************************************************************
  // Microword geometry
  // ****************************************************************
  localparam int WORD_W      = 57;
  localparam int ADDR_W      = 9;
  localparam int CTRL_W      = WORD_W - ADDR_W;
  localparam int STORE_DEPTH = 256;
  localparam int STORE_AW    = 8;
  localparam int ALT_W       = 6;
  localparam int CODE_W      = 5;

  // ****************************************************************
  // Control field positions inside the 48 control bits
  // ****************************************************************
  localparam int BSF_LSB     = 0;
  localparam int BSF_W       = 4;
  localparam int CYC_LSB     = 4;
  localparam int CYC_W       = 2;
  localparam int FLAG_SEL_LSB = 6;
  localparam int FLAG_SEL_W  = 3;
  localparam int IR_SEL_LSB  = 9;
  localparam int IR_SEL_W    = 4;

  // ****************************************************************
  // Cycle types and their pulse counts
  // ****************************************************************
  localparam logic [1:0] CYC_SINGLE_A = 2'h0;
  localparam logic [1:0] CYC_SINGLE_B = 2'h1;
  localparam logic [1:0] CYC_DOUBLE   = 2'h2;
  localparam logic [1:0] PULSES_SINGLE = 2'h1;
  localparam logic [1:0] PULSES_DOUBLE = 2'h2;

  // ****************************************************************
  // Branch select field encodings
  // ****************************************************************
  localparam logic [3:0] BR_NONE    = 4'h0;
  localparam logic [3:0] BR_DISP1   = 4'h1;
  localparam logic [3:0] BR_DISP2   = 4'h2;
  localparam logic [3:0] BR_DISP3   = 4'h3;
  localparam logic [3:0] BR_NARROW  = 4'h4;
  localparam logic [3:0] BR_IR_BIT  = 4'h5;
  localparam logic [3:0] BR_FLAG    = 4'h6;
  localparam logic [3:0] BR_WIDE6   = 4'h7;

  localparam logic [8:0] NEXT_RESET = 9'h000;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [ADDR_W-1:0] next_n;
  } microword_t;

  typedef struct packed {
    logic [CODE_W-1:0] disp1;
    logic [CODE_W-1:0] disp2;
    logic [CODE_W-1:0] disp3;
    logic [15:0]       ir;
    logic [7:0]        flags;
  } branch_src_t;

endpackage : useq_pkg

// >>> branch_source_model.sv
module branch_source_model (
  input  wire logic                  core_clk_in,
  input  wire useq_pkg::branch_src_t want_in,
  output useq_pkg::branch_src_t      src_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Decode and flag outputs settle one clock after the processor changes them.
  always_ff @(posedge core_clk_in)
  begin
    src_out <= want_in;
  end
endmodule // branch_source_model

// >>> test_microprogram_sequencer.sv
module test_microprogram_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]            a;
    useq_pkg::branch_src_t s;
    logic [8:0]            exp;
  } row_t;

  logic                  core_clk;
  logic                  reset;
  logic                  force_req;
  logic [8:0]            force_addr;
  logic [56:0]           option_word;
  logic                  load;
  logic [7:0]            load_addr;
  logic [56:0]           load_data;
  logic [47:0]           control;
  logic [8:0]            next_address;
  logic [8:0]            past_address;
  logic                  state_end;
  useq_pkg::branch_src_t want;
  useq_pkg::branch_src_t src;
  useq_pkg::branch_src_t bg;
  row_t                  rows [10];
  int                    err_total;
  int                    checks;

  branch_source_model u_src (.core_clk_in(core_clk), .want_in(want), .src_out(src));

  microprogram_sequencer u_dut (
    .core_clk_in(core_clk), .reset_in(reset), .branch_src_in(src), .force_in(force_req),
    .force_addr_in(force_addr), .option_word_in(option_word), .load_in(load),
    .load_addr_in(load_addr), .load_data_in(load_data), .control_out(control),
    .next_address_out(next_address), .past_address_out(past_address), .state_end_out(state_end)
  );

  // Word at a: branch select a[2:0], next base {1, a[7:6], 0}, double cycle only at 30.
  function automatic logic [56:0] word_of(input logic [7:0] a);
    logic [47:0] c;
    c = {27'h0, a, 4'hA, 3'h5, (a == 8'h30) ? useq_pkg::CYC_DOUBLE : {1'b0, a[3]}, 1'b0, a[2:0]};
    return {c, ~{1'b1, a[7:6], 6'h00}};
  endfunction

  task automatic check(input logic [56:0] seen, input logic [56:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic drive(input logic f, input logic [7:0] a, input useq_pkg::branch_src_t s);
    @(posedge core_clk);
    force_req  <= f;
    force_addr <= {1'b0, a};
    want       <= s;
  endtask

  task automatic test_done();
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    #16000;
    err_total++;
    test_done();
  end

  initial
  begin
    reset = 1'b1; force_req = 1'b0; force_addr = 9'h000; option_word = 57'h0;
    load = 1'b0; load_addr = 8'h00; load_data = 57'h0; err_total = 0; checks = 0;
    bg = '{5'h15, 5'h0A, 5'h1F, 16'hFFEA, 8'h20};
    want = bg;
    rows[0] = '{8'h40, bg, 9'h140};
    rows[1] = '{8'h81, bg, 9'h195};
    rows[2] = '{8'hC2, bg, 9'h1CA};
    rows[3] = '{8'h03, bg, 9'h11F};
    rows[4] = '{8'h44, bg, 9'h142};
    rows[5] = '{8'h85, bg, 9'h181};
    rows[6] = '{8'hC6, bg, 9'h1C1};
    rows[7] = '{8'h07, bg, 9'h12A};
    rows[8] = '{8'h8D, '{5'h15, 5'h0A, 5'h1F, 16'hFBEA, 8'h20}, 9'h180};
    rows[9] = '{8'hCE, '{5'h15, 5'h0A, 5'h1F, 16'hFFEA, 8'hDF}, 9'h1C0};
    for (int i = 0; i < 256; i++)
    begin
      @(posedge core_clk);
      load      <= 1'b1;
      load_addr <= i[7:0];
      load_data <= word_of(i[7:0]);
    end
    @(posedge core_clk);
    load <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    check(control, word_of(8'h00) >> 9);
    check(next_address, 9'h100);
    check(past_address, 9'h000);
    check(state_end, 1'b1);
    foreach (rows[i])
    begin
      drive(1'b1, rows[i].a, rows[i].s);
      drive(1'b1, rows[i].a, rows[i].s);
      drive(1'b0, 8'h00, rows[i].s);
      @(negedge core_clk);
      check(next_address, {1'b0, rows[i].a});
      @(posedge core_clk);
      @(negedge core_clk);
      check(next_address, rows[i].exp);
      check(past_address, {1'b0, rows[i].a});
      check(control, word_of(rows[i].a) >> 9);
    end
    drive(1'b1, 8'h30, bg);
    drive(1'b1, 8'h30, bg);
    drive(1'b0, 8'h00, bg);
    @(posedge core_clk);
    @(negedge core_clk);
    check(next_address, 9'h030);
    check(state_end, 1'b0);
    @(posedge core_clk);
    @(negedge core_clk);
    check(next_address, 9'h100);
    check(past_address, 9'h030);
    check(state_end, 1'b1);
    @(posedge core_clk);
    reset       <= 1'b1;
    option_word <= 57'h100_0000_0000_0100;
    @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check(control | next_address | past_address, 57'h0);
    @(posedge core_clk);
    option_word <= 57'h0;
    @(negedge core_clk);
    check(control, (word_of(8'h00) >> 9) | 48'h8000_0000_0000);
    check(next_address, 9'h000);
    @(posedge core_clk);
    @(negedge core_clk);
    check(next_address, 9'h100);
    check(past_address, 9'h000);
    test_done();
  end
endmodule // test_microprogram_sequencer
